// ===== verilog/sarc_defines.vh
// Register offsets, field positions and timing counts for the converter control block
// Functional notes
// RULE_01: New result becomes readable only once the conversion is done and flag raised.
// RULE_02: Single-ended result is an unsigned 10-bit code, 0x000 ground to 0x3FF.
// RULE_03: Differential result is signed 10-bit two's complement, 0x200 through 0x1FF.
// RULE_04: Top result bit carries the sign of a differential result.
// RULE_05: Reference select 00 external pin, 01 supply, 10 reserved, 11 internal 1.1V.
// RULE_06: Reference and channel writes take effect only after the running conversion.
// RULE_07: Left-align bit reshapes result bytes immediately, even mid-conversion.
// RULE_08: Channel codes decode to single-ended, pairs against input 1 or 2, bandgap, ground.
// RULE_09: Converter-on bit enables; clearing it aborts any running conversion.
// RULE_10: Software writes go once per conversion in single mode.
// RULE_11: Software writes go once to launch free running conversions.
// RULE_12: First conversion after enable takes 25 cycles, later ones 13.
// RULE_13: Go bit reads one while converting and clears at completion.
// RULE_14: Writing zero to the go bit has no effect.
// RULE_15: With auto trigger on, each rising edge of selected trigger starts conversion; the code ignores an edge while a conversion is running.
// RULE_16: Done flag sets at completion; cleared by vector acknowledge or writing one.
// RULE_17: After low byte read, result pair holds until high byte read.
// RULE_18: Trigger source zero is free running and never itself makes a trigger event.
// RULE_19: Analog core is abstract; a behavioural input supplies the code at the end.
`ifndef SARC_DEFINES_VH
`define SARC_DEFINES_VH
`define SARC_ADDR_CHREF 3'h0
`define SARC_ADDR_CTRL 3'h1
`define SARC_ADDR_TRIG 3'h2
`define SARC_ADDR_RESL 3'h3
`define SARC_ADDR_RESH 3'h4
`define SARC_CHREF_RST 8'h00
`define SARC_REF_HI 7
`define SARC_REF_LO 6
`define SARC_LALIGN 5
`define SARC_CH_HI 4
`define SARC_CTL_ON 7
`define SARC_CTL_GO 6
`define SARC_CTL_AUTO 5
`define SARC_CTL_DONE 4
`define SARC_CYC_FIRST 5'h19
`define SARC_CYC_NORM 5'h0D
`define SARC_REF_EXT 2'h0
`define SARC_REF_SUP 2'h1
`define SARC_REF_RSV 2'h2
`define SARC_REF_INT 2'h3
`endif

// ===== verilog/sarc_sync.v
// Two flip-flop synchroniser for one level
module sarc_sync (
  clk,
  rst_n,
  d,
  q
);
  input clk;
  input rst_n;
  input d;
  output q;
  reg meta_ff;
  reg q_ff;
  assign q = q_ff;
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b0;
      q_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
endmodule // sarc_sync

// ===== verilog/sarc_mux_decode.v
// Input channel and reference decode
`include "sarc_defines.vh"
module sarc_mux_decode (
  chan,
  refs,
  pos_sel,
  neg_sel,
  diff,
  use_bg,
  use_gnd,
  ref_ext,
  ref_sup,
  ref_int
);
  input [4:0] chan;
  input [1:0] refs;
  output reg [2:0] pos_sel;
  output reg [2:0] neg_sel;
  output reg diff;
  output reg use_bg;
  output reg use_gnd;
  output reg ref_ext;
  output reg ref_sup;
  output reg ref_int;
  always @*
  begin
    pos_sel = chan[2:0];
    neg_sel = 3'h0;
    diff = 1'b0;
    use_bg = 1'b0;
    use_gnd = 1'b0;
    if (chan[4:3] == 2'h2)
    begin
      diff = 1'b1; // RULE_08
      neg_sel = 3'h1;
    end
    else if (chan[4:3] == 2'h3)
    begin
      if (chan == 5'h1E)
        use_bg = 1'b1; // RULE_08
      else if (chan == 5'h1F)
        use_gnd = 1'b1;
      else
      begin
        diff = 1'b1; // RULE_08
        neg_sel = 3'h2;
      end
    end
    // Reserved reference code selects nothing
    ref_ext = (refs == `SARC_REF_EXT); // RULE_05
    ref_sup = (refs == `SARC_REF_SUP);
    ref_int = (refs == `SARC_REF_INT);
  end
endmodule // sarc_mux_decode

// ===== verilog/sarc_top.v
// Converter control: registers, conversion sequencer and result presentation
`include "sarc_defines.vh"
module sarc_top (
  clk,
  rst_n,
  addr,
  wdata,
  wr,
  rd,
  rdata,
  vector_ack,
  trig_in,
  conv_code,
  conv_active,
  conv_init,
  pos_sel,
  neg_sel,
  diff_mode,
  bandgap_sel,
  ground_sel,
  ref_ext_sel,
  ref_sup_sel,
  ref_int_sel
);
  input clk;
  input rst_n;
  input [2:0] addr;
  input [7:0] wdata;
  input wr;
  input rd;
  output [7:0] rdata;
  input vector_ack;
  input [7:0] trig_in;
  input [9:0] conv_code;
  output conv_active;
  output conv_init;
  output [2:0] pos_sel;
  output [2:0] neg_sel;
  output diff_mode;
  output bandgap_sel;
  output ground_sel;
  output ref_ext_sel;
  output ref_sup_sel;
  output ref_int_sel;

  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] chref_ff;
  reg [1:0] act_ref_ff;
  reg [4:0] act_ch_ff;
  reg on_ff;
  reg auto_ff;
  reg done_ff;
  reg [2:0] tsel_ff;
  reg [9:0] res_ff;
  reg res_lock_ff;
  reg [9:0] pend_ff;
  reg pend_ff_v;
  reg [1:0] state_ff;
  reg [4:0] cnt_ff;
  reg first_ff;
  reg init_ff;
  reg [7:0] rdata_ff;
  reg trig_prev_ff;
  reg [2:0] pos_ff;
  reg [2:0] neg_ff;
  reg diff_ff;
  reg bg_ff;
  reg gnd_ff;
  reg rext_ff;
  reg rsup_ff;
  reg rint_ff;

  wire [7:0] trig_s;
  wire [2:0] dec_pos;
  wire [2:0] dec_neg;
  wire dec_diff;
  wire dec_bg;
  wire dec_gnd;
  wire dec_ext;
  wire dec_sup;
  wire dec_int;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_sync
      sarc_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(trig_in[gi]),
        .q(trig_s[gi])
      );
    end
  endgenerate

  sarc_mux_decode u_dec (
    .chan(act_ch_ff),
    .refs(act_ref_ff),
    .pos_sel(dec_pos),
    .neg_sel(dec_neg),
    .diff(dec_diff),
    .use_bg(dec_bg),
    .use_gnd(dec_gnd),
    .ref_ext(dec_ext),
    .ref_sup(dec_sup),
    .ref_int(dec_int)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Start and trigger logic
  wire wr_chref = wr && (addr == `SARC_ADDR_CHREF);
  wire wr_ctrl = wr && (addr == `SARC_ADDR_CTRL);
  wire wr_trig = wr && (addr == `SARC_ADDR_TRIG);
  wire nxt_on = wr_ctrl ? wdata[`SARC_CTL_ON] : on_ff;
  wire busy = (state_ff == ST_CONV);
  wire sw_go = wr_ctrl && wdata[`SARC_CTL_GO]; // RULE_14
  // Source zero is the free running path, so trigger source is masked there
  wire trig_cur = (tsel_ff == 3'h0) ? 1'b0 : trig_s[tsel_ff]; // RULE_18
  wire trig_rise = trig_cur && !trig_prev_ff; // RULE_15
  wire conv_end = busy && (cnt_ff == 5'h01);
  wire free_run = auto_ff && (tsel_ff == 3'h0) && conv_end; // RULE_11
  wire auto_go = auto_ff && trig_rise; // RULE_15
  wire start = nxt_on && !busy && (sw_go || auto_go);
  wire restart = on_ff && free_run && nxt_on;
  wire abort = busy && !nxt_on; // RULE_09

  ////////////////////////////////////////////////////////////////////////////
  // Result presentation
  wire lalign = chref_ff[`SARC_LALIGN];
  // Left-align is read live from the register, never latched per conversion
  wire [15:0] shaped = lalign ? {res_ff, 6'h00} : {6'h00, res_ff}; // RULE_07

  reg [7:0] nxt_rdata;
  always @*
  begin
    nxt_rdata = 8'h00;
    if (rd)
    begin
      case (addr)
        `SARC_ADDR_CHREF: nxt_rdata = chref_ff;
        `SARC_ADDR_CTRL: nxt_rdata = {on_ff, busy, auto_ff, done_ff, 4'h0}; // RULE_13
        `SARC_ADDR_TRIG: nxt_rdata = {5'h00, tsel_ff};
        `SARC_ADDR_RESL: nxt_rdata = shaped[7:0];
        `SARC_ADDR_RESH: nxt_rdata = shaped[15:8]; // RULE_04
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and register state
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      chref_ff <= `SARC_CHREF_RST;
      act_ref_ff <= 2'h0;
      act_ch_ff <= 5'h00;
      on_ff <= 1'b0;
      auto_ff <= 1'b0;
      done_ff <= 1'b0;
      tsel_ff <= 3'h0;
      res_ff <= 10'h000;
      res_lock_ff <= 1'b0;
      pend_ff <= 10'h000;
      pend_ff_v <= 1'b0;
      state_ff <= ST_IDLE;
      cnt_ff <= 5'h00;
      first_ff <= 1'b1;
      init_ff <= 1'b0;
      rdata_ff <= 8'h00;
      trig_prev_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      trig_prev_ff <= trig_cur;
      if (wr_chref)
        chref_ff <= wdata;
      if (wr_trig)
        tsel_ff <= wdata[2:0];
      on_ff <= nxt_on;
      if (wr_ctrl)
        auto_ff <= wdata[`SARC_CTL_AUTO];
      if (!on_ff && nxt_on)
        first_ff <= 1'b1; // RULE_12
      // Completion wins over a clear in the same cycle
      if (conv_end && on_ff)
        done_ff <= 1'b1; // RULE_16
      else if (vector_ack || (wr_ctrl && wdata[`SARC_CTL_DONE]))
        done_ff <= 1'b0; // RULE_16
      if (rd && addr == `SARC_ADDR_RESL)
        res_lock_ff <= 1'b1; // RULE_17
      else if (rd && addr == `SARC_ADDR_RESH)
        res_lock_ff <= 1'b0;
      // Held result moves in only once the pair has been read out
      if (pend_ff_v && !res_lock_ff)
      begin
        res_ff <= pend_ff; // RULE_17
        pend_ff_v <= 1'b0;
      end
      case (state_ff)
        ST_IDLE:
        begin
          if (start)
          begin
            state_ff <= ST_CONV;
            act_ref_ff <= chref_ff[`SARC_REF_HI:`SARC_REF_LO]; // RULE_06
            act_ch_ff <= chref_ff[`SARC_CH_HI:0]; // RULE_06
            // A start together with enable is also the long first conversion
            init_ff <= first_ff || !on_ff;
            cnt_ff <= (first_ff || !on_ff) ? `SARC_CYC_FIRST : `SARC_CYC_NORM; // RULE_12
            first_ff <= 1'b0;
          end
        end
        ST_CONV:
        begin
          if (abort)
          begin
            state_ff <= ST_IDLE; // RULE_09
            cnt_ff <= 5'h00;
            init_ff <= 1'b0;
          end
          else if (conv_end)
          begin
            // Code is passed raw: two's complement for pairs, unsigned otherwise
            if (res_lock_ff)
            begin
              pend_ff <= conv_code; // RULE_19
              pend_ff_v <= 1'b1;
            end
            else
              res_ff <= conv_code; // RULE_01 RULE_02 RULE_03
            init_ff <= 1'b0;
            act_ref_ff <= chref_ff[`SARC_REF_HI:`SARC_REF_LO]; // RULE_06
            act_ch_ff <= chref_ff[`SARC_CH_HI:0];
            if (restart)
              cnt_ff <= `SARC_CYC_NORM; // RULE_11
            else
            begin
              state_ff <= ST_IDLE; // RULE_13
              cnt_ff <= 5'h00;
            end
          end
          else
            cnt_ff <= cnt_ff - 5'h01;
        end
        default:
        begin
          state_ff <= ST_IDLE;
          cnt_ff <= 5'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog side selections, registered
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pos_ff <= 3'h0;
      neg_ff <= 3'h0;
      diff_ff <= 1'b0;
      bg_ff <= 1'b0;
      gnd_ff <= 1'b0;
      rext_ff <= 1'b0;
      rsup_ff <= 1'b0;
      rint_ff <= 1'b0;
    end
    else
    begin
      pos_ff <= dec_pos; // RULE_08
      neg_ff <= dec_neg;
      diff_ff <= dec_diff;
      bg_ff <= dec_bg;
      gnd_ff <= dec_gnd;
      // Internal reference stays off unless chosen and converter is on
      rext_ff <= dec_ext; // RULE_05
      rsup_ff <= dec_sup && on_ff;
      rint_ff <= dec_int && on_ff;
    end
  end

  reg act_ff;
  always @(posedge clk)
  begin
    if (!rst_n)
      act_ff <= 1'b0;
    else
      act_ff <= busy;
  end

  assign rdata = rdata_ff;
  assign conv_active = act_ff;
  assign conv_init = init_ff;
  assign pos_sel = pos_ff;
  assign neg_sel = neg_ff;
  assign diff_mode = diff_ff;
  assign bandgap_sel = bg_ff;
  assign ground_sel = gnd_ff;
  assign ref_ext_sel = rext_ff;
  assign ref_sup_sel = rsup_ff;
  assign ref_int_sel = rint_ff;
endmodule // sarc_top

// ===== verification/sarc_analog_model.sv
// Behavioural analog pins and references that feed the converter code
module sarc_analog_model (
  input logic [2:0] pos_sel,
  input logic [2:0] neg_sel,
  input logic diff_mode,
  input logic bandgap_sel,
  input logic ground_sel,
  output logic [9:0] conv_code
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each pin sits at its own level; a pair gives 64 codes per step of difference
  always_comb
    if (ground_sel)
      conv_code = 10'h000;
    else if (bandgap_sel)
      conv_code = 10'h1C0;
    else if (diff_mode)
      conv_code = ({7'h00, pos_sel} - {7'h00, neg_sel}) << 6;
    else
      conv_code = {pos_sel, 7'h2A};
endmodule // sarc_analog_model

// ===== verification/sarc_top_props.sv
// Concurrent checks on the converter control ports
`include "sarc_defines.vh"
module sarc_top_props (
  input logic clk,
  input logic rst_n,
  input logic [2:0] addr,
  input logic [7:0] wdata,
  input logic wr,
  input logic rd,
  input logic [7:0] rdata,
  input logic vector_ack,
  input logic [7:0] trig_in,
  input logic [9:0] conv_code,
  input logic conv_active,
  input logic conv_init,
  input logic [2:0] pos_sel,
  input logic [2:0] neg_sel,
  input logic diff_mode,
  input logic bandgap_sel,
  input logic ground_sel,
  input logic ref_ext_sel,
  input logic ref_sup_sel,
  input logic ref_int_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] init_cnt_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Counter instead of a long repetition, which the tools unroll
  always_ff @(posedge clk)
    init_cnt_ff <= (!rst_n || !conv_init) ? 8'h00 : init_cnt_ff + 8'h01;
  AST_RD_IDLE:
    assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside answer");
  AST_GO_BUSY:
    assert property ($rose(conv_init) ##[3:4] (rd && addr == `SARC_ADDR_CTRL) |=> rdata[6])
    else $error("go bit low while busy");
  AST_OFF_ABORT:
    assert property (wr && addr == `SARC_ADDR_CTRL && !wdata[`SARC_CTL_ON] |-> ##2 !conv_active)
    else $error("conversion survived off");
  AST_INIT_LEN:
    assert property (conv_init |-> init_cnt_ff < 8'h19)
    else $error("first conversion too long");
  AST_SEL_HOLD:
    assert property (conv_init[*3] |-> $stable(pos_sel) && $stable(neg_sel)
      && $stable(diff_mode) && $stable(ref_int_sel) && $stable(ref_ext_sel))
    else $error("selection moved mid conversion");
  AST_REF_ONE:
    assert property ($onehot0({ref_ext_sel, ref_sup_sel, ref_int_sel}))
    else $error("two references at once");
  AST_CH_EXCL:
    assert property ($onehot0({diff_mode, bandgap_sel, ground_sel}))
    else $error("channel decode overlap");
  AST_DONE_ACK:
    assert property (vector_ack && !conv_active ##[1:2]
      (rd && addr == `SARC_ADDR_CTRL && !conv_active) |=> !rdata[4])
    else $error("done flag survived ack");
endmodule // sarc_top_props

// ===== verification/tb_sarc.sv
// Self-checking bench for the converter control block
`include "sarc_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic vector_ack = 1'b0;
  logic [7:0] trig_in = 8'h00;
  wire [7:0] rdata;
  wire [9:0] conv_code;
  wire [2:0] pos_sel, neg_sel;
  wire conv_active, conv_init, diff_mode, bandgap_sel, ground_sel, ref_ext_sel, ref_sup_sel;
  wire ref_int_sel;
  int err_count = 0;
  int compares = 0;
  int act_cnt = 0;
  int act_base = 0;
  logic [7:0] d, lo, hi;
  logic [7:0] ch_tab [5] = '{8'h05, 8'h58, 8'hDE, 8'h5F, 8'h57};
  logic [9:0] code_tab [5] = '{10'h2AA, 10'h380, 10'h1C0, 10'h000, 10'h180};
  logic [2:0] ref_tab [5] = '{3'h4, 3'h2, 3'h1, 3'h2, 3'h2};
  sarc_top DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .vector_ack(vector_ack), .trig_in(trig_in), .conv_code(conv_code),
    .conv_active(conv_active), .conv_init(conv_init), .pos_sel(pos_sel), .neg_sel(neg_sel),
    .diff_mode(diff_mode), .bandgap_sel(bandgap_sel), .ground_sel(ground_sel),
    .ref_ext_sel(ref_ext_sel), .ref_sup_sel(ref_sup_sel), .ref_int_sel(ref_int_sel));
  sarc_analog_model u_analog (.pos_sel(pos_sel), .neg_sel(neg_sel), .diff_mode(diff_mode),
    .bandgap_sel(bandgap_sel), .ground_sel(ground_sel), .conv_code(conv_code));
  initial
    forever #2.5 clk = ~clk;
  always @(posedge clk)
    if (conv_active)
      act_cnt <= act_cnt + 1;
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Polls the done flag; a lost completion must not hang the run
  task automatic wait_done();
    for (int i = 0; i < 60; i++)
    begin
      rd_reg(`SARC_ADDR_CTRL, d);
      compares++;
      if (d[`SARC_CTL_DONE] === 1'b1)
        return;
    end
    err_count++;
    $display("[ERR] %0t no completion", $time);
    report_and_stop();
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`SARC_ADDR_CHREF, d);
    chk(d, `SARC_CHREF_RST);
    wr_reg(`SARC_ADDR_RESL, 8'hFF);
    rd_reg(`SARC_ADDR_RESL, d);
    chk(d, 8'h00);
    // Low byte read locks the pair; release it before any result arrives
    rd_reg(`SARC_ADDR_RESH, d);
    chk(d, 8'h00);
    rd_reg(3'h7, d);
    chk(d, 8'h00);
    $display("Test map end");
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(`SARC_ADDR_CHREF, ch_tab[i]);
      act_base = act_cnt;
      wr_reg(`SARC_ADDR_CTRL, 8'hD0);
      wait_done();
      chk(16'(act_cnt - act_base), (i == 0) ? 16'h0019 : 16'h000D);
      chk({ref_ext_sel, ref_sup_sel, ref_int_sel}, ref_tab[i]);
      rd_reg(`SARC_ADDR_RESL, lo);
      rd_reg(`SARC_ADDR_RESH, hi);
      chk({hi, lo}, {6'h00, code_tab[i]});
      wr_reg(`SARC_ADDR_CHREF, ch_tab[i] | 8'h20);
      rd_reg(`SARC_ADDR_RESL, lo);
      rd_reg(`SARC_ADDR_RESH, hi);
      chk({hi, lo}, {code_tab[i], 6'h00});
    end
    $display("Test table end");
    wr_reg(`SARC_ADDR_CHREF, 8'h05);
    wr_reg(`SARC_ADDR_CTRL, 8'hD0);
    wr_reg(`SARC_ADDR_CHREF, 8'h1F);
    wr_reg(`SARC_ADDR_CTRL, 8'h80);
    wait_done();
    rd_reg(`SARC_ADDR_CTRL, d);
    chk(d, 8'h90);
    rd_reg(`SARC_ADDR_RESL, lo);
    chk(lo, 8'hAA);
    wr_reg(`SARC_ADDR_CTRL, 8'hD0);
    wait_done();
    rd_reg(`SARC_ADDR_RESH, hi);
    chk(hi, 8'h02);
    rd_reg(`SARC_ADDR_RESL, lo);
    rd_reg(`SARC_ADDR_RESH, hi);
    chk({hi, lo}, 16'h0000);
    $display("Test hold end");
    wr_reg(`SARC_ADDR_CTRL, 8'hD0);
    repeat (3) @(posedge clk);
    wr_reg(`SARC_ADDR_CTRL, 8'h10);
    rd_reg(`SARC_ADDR_CTRL, d);
    chk(d, 8'h00);
    act_base = act_cnt;
    wr_reg(`SARC_ADDR_CTRL, 8'hC0);
    wait_done();
    chk(16'(act_cnt - act_base), 16'h0019);
    @(posedge clk);
    vector_ack <= 1'b1;
    @(posedge clk);
    vector_ack <= 1'b0;
    rd_reg(`SARC_ADDR_CTRL, d);
    chk(d, 8'h80);
    $display("Test abort end");
    wr_reg(`SARC_ADDR_TRIG, 8'h03);
    wr_reg(`SARC_ADDR_CTRL, 8'hB0);
    trig_in <= 8'h08;
    wait_done();
    wr_reg(`SARC_ADDR_TRIG, 8'h00);
    repeat (4) @(posedge clk);
    rd_reg(`SARC_ADDR_CTRL, d);
    chk(d, 8'hB0);
    wr_reg(`SARC_ADDR_CTRL, 8'hF0);
    wait_done();
    wr_reg(`SARC_ADDR_CTRL, 8'hB0);
    wait_done();
    wr_reg(`SARC_ADDR_CTRL, 8'h00);
    $display("Test trigger end");
    report_and_stop();
  end
endmodule // tb
bind sarc_top sarc_top_props u_props (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .vector_ack(vector_ack), .trig_in(trig_in),
  .conv_code(conv_code), .conv_active(conv_active), .conv_init(conv_init),
  .pos_sel(pos_sel), .neg_sel(neg_sel), .diff_mode(diff_mode), .bandgap_sel(bandgap_sel),
  .ground_sel(ground_sel), .ref_ext_sel(ref_ext_sel), .ref_sup_sel(ref_sup_sel),
  .ref_int_sel(ref_int_sel));
